// ==== design/rtcac_core.sv ====
// Purpose: Alarm, flag and control registers of a calendar real-time clock
// Assumes: Time counters sit outside and talk over match, carry, run and round
// Notes:   rst is power-on reset; manual_rst is a same-domain level input
//
// Notes on behaviour
// - Month alarm: enable, zeros, BCD tens, units
// - Alarm when all enabled fields coincide
// - Power-on clears month enable; digits kept
// - Flag control zero at power-on; manual keeps carry
// - Counter read during carry sets carry flag
// - Write 0 clears carry flag, 1 sets
// - Carry irq when flag and enable set
// - Alarm irq when flag and enable set
// - Alarm flag set on match; write 0 clears
// - Reserved flag control bits read zero
// - Run control 09 at power-on; manual keeps run bits
// - Periodic flag set each period, irq raised
// - Period select encodes none to two seconds
// - Oscillator run bit gates crystal, default 1
// - Round: seconds to 00 or next minute
// - Round also resets divider, quickly visible
// - Divider reset clears prescaler and sub counter
// - Count run bit stops calendar counters
// - Sub-second counter stops only with oscillator
`timescale 1ns/1ps

module rtcac_core (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       manual_rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       rtc_crystal_pin,
    input  wire logic [7:0] month_counter,
    input  wire logic       other_alarm_any_en,
    input  wire logic       other_alarm_match,
    input  wire logic       counter_read,
    input  wire logic       sec_carry,
    output logic            sec_tick,
    output logic            thirty_second_round,
    output logic            osc_run,
    output logic            count_run,
    output logic            carry_irq,
    output logic            alarm_irq,
    output logic            periodic_irq
);
    rtcac_pkg::rtcac_state_type s;      // Registered state
    rtcac_pkg::rtcac_state_type next_s; // Next state

    logic       wr_mon;      // Write to month alarm
    logic       wr_flag;     // Write to flag control
    logic       wr_run;      // Write to run control
    logic       xtal_rise;   // Crystal rising edge while running
    logic       tick;        // One 1/256 s step
    logic [8:0] sub_inc;     // Sub counter plus one
    logic       sub_carry;   // Sub counter wraps a second
    logic       period_hit;  // Selected period elapsed
    logic       month_eq;    // Month digits match counter
    logic       alarm_now;   // All enabled fields coincide
    logic       alarm_rise;  // Start of a coincidence
    logic       carry_read;  // Counter read during a carry

    // Period mask on the incremented sub counter
    function automatic logic [8:0] period_mask(input logic [2:0] sel);
        logic [8:0] m;
        m = 9'h000;
        unique case (sel)
            3'h0: m = 9'h000;
            3'h1: m = 9'h000; // 1/256 s
            3'h2: m = 9'h003; // 1/64 s
            3'h3: m = 9'h00f; // 1/16 s
            3'h4: m = 9'h03f; // 1/4 s
            3'h5: m = 9'h07f; // 1/2 s
            3'h6: m = 9'h0ff; // 1 s
            3'h7: m = 9'h1ff; // 2 s
        endcase
        return m;
    endfunction : period_mask

    // Address decode
    assign wr_mon  = wr && (addr == rtcac_pkg::MON_ALARM_OFS);
    assign wr_flag = wr && (addr == rtcac_pkg::FLAG_CTRL_OFS);
    assign wr_run  = wr && (addr == rtcac_pkg::RUN_CTRL_OFS);

    // Crystal edge, counted only while the oscillator runs
    assign xtal_rise = s.xtal_s2 && !s.xtal_s3 && s.osc_run;
    assign tick      = xtal_rise && (s.presc == rtcac_pkg::PRESC_LAST);
    assign sub_inc   = s.sub + 9'h001;
    assign sub_carry = tick && (sub_inc[7:0] == 8'h00);
    // Period select decode
    assign period_hit = tick && (s.period_select != 3'h0)
                        && ((sub_inc & period_mask(s.period_select)) == 9'h000);

    // Alarm coincidence over enabled fields
    assign month_eq   = ({3'h0, s.mon_tens, s.mon_units} == month_counter);
    assign alarm_now  = (s.mon_en || other_alarm_any_en)
                        && (!s.mon_en || month_eq) && other_alarm_match;
    assign alarm_rise = alarm_now && !s.match_d;
    assign carry_read = counter_read && (sec_carry || sub_carry);

    // Next-state logic
    always_comb begin
        next_s = s;
        // Crystal synchroniser and edge history
        next_s.xtal_s1 = rtc_crystal_pin;
        next_s.xtal_s2 = s.xtal_s1;
        next_s.xtal_s3 = s.xtal_s2;
        next_s.match_d = alarm_now;

        // Divider chain runs regardless of count run
        if (xtal_rise) begin
            next_s.presc = s.presc + 7'h01;
        end
        if (tick) begin
            next_s.sub = sub_inc;
        end
        // Seconds step only while counting
        next_s.sec_tick = sub_carry && s.count_run;

        // Month alarm writes
        if (wr_mon) begin
            next_s.mon_en    = wdata[rtcac_pkg::MON_EN_BIT];
            next_s.mon_tens  = wdata[rtcac_pkg::MON_TENS_BIT];
            next_s.mon_units = wdata[3:0];
        end

        // Flag control writes
        if (wr_flag) begin
            next_s.carry_flag = wdata[rtcac_pkg::CARRY_BIT];
            next_s.carry_ie   = wdata[rtcac_pkg::CARRY_IE_BIT];
            next_s.alarm_ie   = wdata[rtcac_pkg::ALARM_IE_BIT];
            if (!wdata[rtcac_pkg::ALARM_HIT_BIT]) begin
                next_s.alarm_hit_flag = 1'b0;
            end
        end

        // Run control writes
        next_s.round_pulse = wr_run && wdata[rtcac_pkg::ROUND_BIT];
        if (wr_run) begin
            next_s.periodic_flag = wdata[rtcac_pkg::PERIODIC_BIT];
            next_s.period_select = wdata[rtcac_pkg::PERIOD_SEL_LSB +: 3];
            next_s.osc_run       = wdata[rtcac_pkg::OSC_RUN_BIT];
            next_s.count_run     = wdata[rtcac_pkg::COUNT_RUN_BIT];
            if (wdata[rtcac_pkg::ROUND_BIT] || wdata[rtcac_pkg::DIV_RST_BIT]) begin
                next_s.presc = 7'h00;
                next_s.sub   = 9'h000;
            end
        end

        // Hardware sets win over software clears
        if (carry_read) begin
            next_s.carry_flag = 1'b1;
        end
        if (alarm_rise) begin
            next_s.alarm_hit_flag = 1'b1;
        end
        if (period_hit) begin
            next_s.periodic_flag = 1'b1;
        end

        // Manual reset keeps carry, oscillator and count run
        if (manual_rst) begin
            next_s.carry_ie       = 1'b0;
            next_s.alarm_ie       = 1'b0;
            next_s.alarm_hit_flag = 1'b0;
            next_s.periodic_flag  = 1'b0;
            next_s.period_select  = 3'h0;
            next_s.round_pulse    = 1'b0;
        end

        // Read data, valid the cycle after the strobe
        next_s.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                rtcac_pkg::MON_ALARM_OFS:
                    next_s.rdata = {s.mon_en, 2'b00, s.mon_tens, s.mon_units};
                rtcac_pkg::FLAG_CTRL_OFS:
                    next_s.rdata = {s.carry_flag, 2'b00, s.carry_ie, s.alarm_ie,
                                    2'b00, s.alarm_hit_flag};
                rtcac_pkg::RUN_CTRL_OFS:
                    next_s.rdata = {s.periodic_flag, s.period_select, s.osc_run,
                                    2'b00, s.count_run};
                rtcac_pkg::SUB_CNT_OFS:
                    next_s.rdata = s.sub[7:0];
                default:
                    next_s.rdata = 8'h00;
            endcase
        end

        // Carry and alarm irq levels follow flag and enable; periodic irq follows its flag alone
        next_s.carry_irq    = next_s.carry_flag && next_s.carry_ie;
        next_s.alarm_irq    = next_s.alarm_hit_flag && next_s.alarm_ie;
        next_s.periodic_irq = next_s.periodic_flag;
    end

    // State register; month digits are not touched by power-on reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s.mon_en         <= 1'b0;
            s.carry_flag     <= rtcac_pkg::FLAG_CTRL_POR[rtcac_pkg::CARRY_BIT];
            s.carry_ie       <= rtcac_pkg::FLAG_CTRL_POR[rtcac_pkg::CARRY_IE_BIT];
            s.alarm_ie       <= rtcac_pkg::FLAG_CTRL_POR[rtcac_pkg::ALARM_IE_BIT];
            s.alarm_hit_flag <= rtcac_pkg::FLAG_CTRL_POR[rtcac_pkg::ALARM_HIT_BIT];
            s.periodic_flag  <= rtcac_pkg::RUN_CTRL_POR[rtcac_pkg::PERIODIC_BIT];
            s.period_select  <= rtcac_pkg::RUN_CTRL_POR[rtcac_pkg::PERIOD_SEL_LSB +: 3];
            s.osc_run        <= rtcac_pkg::RUN_CTRL_POR[rtcac_pkg::OSC_RUN_BIT];
            s.count_run      <= rtcac_pkg::RUN_CTRL_POR[rtcac_pkg::COUNT_RUN_BIT];
            s.presc          <= 7'h00;
            s.sub            <= 9'h000;
            s.xtal_s1        <= 1'b0;
            s.xtal_s2        <= 1'b0;
            s.xtal_s3        <= 1'b0;
            s.match_d        <= 1'b0;
            s.rdata          <= 8'h00;
            s.carry_irq      <= 1'b0;
            s.alarm_irq      <= 1'b0;
            s.periodic_irq   <= 1'b0;
            s.sec_tick       <= 1'b0;
            s.round_pulse    <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign rdata               = s.rdata;
    assign sec_tick            = s.sec_tick;
    assign thirty_second_round = s.round_pulse;
    assign osc_run             = s.osc_run;
    assign count_run           = s.count_run;
    assign carry_irq           = s.carry_irq;
    assign alarm_irq           = s.alarm_irq;
    assign periodic_irq        = s.periodic_irq;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    localparam int ROUND_WAIT = 1;

    property p_month_read;
        rd && (addr == rtcac_pkg::MON_ALARM_OFS) |=> (rdata[6:5] == 2'b00)
            && (rdata[7] == $past(s.mon_en));
    endproperty
    a_month_read: assert property (p_month_read) else $error("month alarm readback wrong");

    property p_alarm_set;
        alarm_rise && !manual_rst |=> s.alarm_hit_flag && (alarm_irq == s.alarm_ie);
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

    property p_carry_set;
        carry_read && !manual_rst |=> s.carry_flag;
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry flag not set");

    property p_carry_clr;
        wr_flag && !wdata[rtcac_pkg::CARRY_BIT] && !carry_read |=> !s.carry_flag;
    endproperty
    a_carry_clr: assert property (p_carry_clr) else $error("carry flag not cleared");

    property p_carry_irq;
        carry_irq == (s.carry_flag && s.carry_ie);
    endproperty
    a_carry_irq: assert property (p_carry_irq) else $error("carry irq mismatch");

    property p_alarm_irq;
        alarm_irq == (s.alarm_hit_flag && s.alarm_ie);
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq mismatch");

    property p_flag_rsvd;
        rd && (addr == rtcac_pkg::FLAG_CTRL_OFS) |=> (rdata[6:5] == 2'b00)
            && (rdata[2:1] == 2'b00);
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved bits not zero");

    property p_run_wo;
        rd && (addr == rtcac_pkg::RUN_CTRL_OFS) |=> (rdata[2:1] == 2'b00);
    endproperty
    a_run_wo: assert property (p_run_wo) else $error("write-only bits read back");

    property p_round;
        wr_run && wdata[rtcac_pkg::ROUND_BIT] && !manual_rst |-> ##[ROUND_WAIT:ROUND_WAIT]
            (thirty_second_round && (s.sub == 9'h000) && (s.presc == 7'h00))
            ##1 !thirty_second_round;
    endproperty
    a_round: assert property (p_round) else $error("round pulse or divider reset wrong");

    property p_tick_run;
        sec_tick |-> $past(s.count_run);
    endproperty
    a_tick_run: assert property (p_tick_run) else $error("second step while stopped");

    property p_osc_hold;
        !s.osc_run && !wr_run |=> $stable(s.sub) && $stable(s.presc);
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("divider moved while halted");

    property p_periodic;
        period_hit && !manual_rst |=> s.periodic_flag && periodic_irq;
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic flag not set");

    property p_periodic_clr;
        wr_run && !wdata[rtcac_pkg::PERIODIC_BIT] && !period_hit
            |=> !s.periodic_flag && !periodic_irq;
    endproperty
    a_periodic_clr: assert property (p_periodic_clr) else $error("periodic flag kept");

    // Manual reset and divider reset
    property p_manual_flag;
        manual_rst |=> !s.carry_ie && !s.alarm_ie && !s.alarm_hit_flag && !alarm_irq;
    endproperty
    a_manual_flag: assert property (p_manual_flag) else $error("flag bits kept");

    property p_manual_run;
        manual_rst && !wr_run |=> !s.periodic_flag && (s.period_select == 3'h0)
            && $stable(s.osc_run) && $stable(s.count_run);
    endproperty
    a_manual_run: assert property (p_manual_run) else $error("run control reset wrong");

    property p_month_keep;
        manual_rst && !wr_mon |=> $stable(s.mon_en) && $stable(s.mon_tens)
            && $stable(s.mon_units);
    endproperty
    a_month_keep: assert property (p_month_keep) else $error("month alarm lost");

    property p_div_reset;
        wr_run && wdata[rtcac_pkg::DIV_RST_BIT] |=> (s.sub == 9'h000) && (s.presc == 7'h00);
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not reset");

    c_alarm_irq: cover property ($rose(alarm_irq));
    c_periodic:  cover property ($rose(periodic_irq));
    c_carry:     cover property (carry_read ##1 carry_irq);
    c_round:     cover property (thirty_second_round);
    c_manual:    cover property (manual_rst ##1 !manual_rst);
endmodule : rtcac_core

// ==== design/rtcac_pkg.sv ====
// Purpose: Shared constants and carriers for the RTC alarm and control block
// Assumes: 20 MHz core clock, 32.768 kHz crystal sampled as a plain input
// Notes:   Register offsets are byte addresses on the plain register port
package rtcac_pkg;
    // Register byte offsets
    localparam logic [7:0] MON_ALARM_OFS = 8'h00; // Month alarm match
    localparam logic [7:0] FLAG_CTRL_OFS = 8'h04; // Flag and irq enable control
    localparam logic [7:0] RUN_CTRL_OFS  = 8'h08; // Period, oscillator and count control
    localparam logic [7:0] SUB_CNT_OFS   = 8'h0C; // Sub-second counter, read only

    // Power-on values
    localparam logic [7:0] FLAG_CTRL_POR = 8'h00;
    localparam logic [7:0] RUN_CTRL_POR  = 8'h09;

    // Field positions
    localparam int MON_EN_BIT     = 7; // Month alarm field enable
    localparam int MON_TENS_BIT   = 4; // Month tens digit
    localparam int CARRY_BIT      = 7; // Carry flag
    localparam int CARRY_IE_BIT   = 4; // Carry irq enable
    localparam int ALARM_IE_BIT   = 3; // Alarm irq enable
    localparam int ALARM_HIT_BIT  = 0; // Alarm hit flag
    localparam int PERIODIC_BIT   = 7; // Periodic flag
    localparam int PERIOD_SEL_LSB = 4; // Period select, three bits
    localparam int OSC_RUN_BIT    = 3; // Oscillator run
    localparam int ROUND_BIT      = 2; // Thirty second round, write only
    localparam int DIV_RST_BIT    = 1; // Divider reset, write only
    localparam int COUNT_RUN_BIT  = 0; // Counter run

    // Crystal edges per 1/256 s step, minus one
    localparam logic [6:0] PRESC_LAST = 7'h7f;

    // Round result must be visible within this time
    localparam int CLK_PERIOD_NS   = 50;
    localparam int ROUND_LIMIT_NS  = 91600;
    localparam int ROUND_LIMIT_CYC = ROUND_LIMIT_NS / CLK_PERIOD_NS;

    // Whole state of the block
    typedef struct packed {
        logic       mon_en;       // Month alarm field enable
        logic       mon_tens;     // Month tens digit
        logic [3:0] mon_units;    // Month units digit
        logic       carry_flag;
        logic       carry_ie;
        logic       alarm_ie;
        logic       alarm_hit_flag;
        logic       periodic_flag;
        logic [2:0] period_select;
        logic       osc_run;
        logic       count_run;
        logic [6:0] presc;        // Crystal edge prescaler
        logic [8:0] sub;          // Sub-second counter, 1/256 s steps, 2 s span
        logic       xtal_s1;      // Synchroniser first stage
        logic       xtal_s2;      // Synchroniser second stage
        logic       xtal_s3;      // Edge history
        logic       match_d;      // Alarm coincidence, last cycle
        logic [7:0] rdata;
        logic       carry_irq;
        logic       alarm_irq;
        logic       periodic_irq;
        logic       sec_tick;
        logic       round_pulse;
    } rtcac_state_type;
endpackage : rtcac_pkg

// ==== verification/rtcac_tb.sv ====
// Purpose: Self-checking bench for the RTC alarm and control block
// Assumes: Bench drives a fast stand-in crystal, one edge pair per 8 cycles
// Notes:   Periods are scaled to that crystal; long select codes are readback only
`timescale 1ns/1ps

module testbench;
    logic       core_clk;            // 20 MHz core clock
    logic       rst;                 // Power-on reset
    logic       manual_rst;          // Manual reset level
    logic [7:0] addr;                // Register address
    logic [7:0] wdata;               // Write data
    logic       wr;                  // Write strobe
    logic       rd;                  // Read strobe
    logic [7:0] rdata;               // Read data
    logic       rtc_crystal_pin;     // Stand-in crystal
    logic [7:0] month_counter;       // Month count from outside
    logic       other_alarm_any_en;  // Another alarm field enabled
    logic       other_alarm_match;   // Other enabled fields coincide
    logic       counter_read;        // Software reads a counter
    logic       sec_carry;           // Seconds counter carries
    logic       sec_tick;            // Per-second pulse
    logic       thirty_second_round; // Round request pulse
    logic       osc_run;             // Oscillator run level
    logic       count_run;           // Counter run level
    logic       carry_irq;           // Carry request
    logic       alarm_irq;           // Alarm request
    logic       periodic_irq;        // Periodic request
    int         mismatches;          // Failed compares
    int         check_count;         // All compares
    int         cyc;                 // Free-running cycle count
    logic [1:0] xdiv;                // Crystal toggle divider

    rtcac_core i_rtcac_core (
        .core_clk(core_clk), .rst(rst), .manual_rst(manual_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rtc_crystal_pin(rtc_crystal_pin),
        .month_counter(month_counter), .other_alarm_any_en(other_alarm_any_en),
        .other_alarm_match(other_alarm_match), .counter_read(counter_read),
        .sec_carry(sec_carry), .sec_tick(sec_tick), .thirty_second_round(thirty_second_round),
        .osc_run(osc_run), .count_run(count_run), .carry_irq(carry_irq),
        .alarm_irq(alarm_irq), .periodic_irq(periodic_irq)
    );

    // Clock generator
    always #25 core_clk = ~core_clk;

    // Crystal, cycle count and hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        xdiv <= xdiv + 2'd1;
        if (xdiv == 2'd3) begin
            rtc_crystal_pin <= ~rtc_crystal_pin;
        end
        if (cyc == 70000) begin
            mismatches = mismatches + 1;
            conclude();
        end
    end

    // Count and report one compare
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Single-bit compare
    task automatic check_bit(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask : check_bit

    // Cycle distance within a small window of its nominal value
    task automatic check_near(input int got, input int exp);
        check_count++;
        if (got < exp - 16 || got > exp + 16) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_near

    // One write cycle; returns just after the taking edge
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask : reg_write

    // One read cycle; data taken in the cycle after the strobe
    task automatic reg_check(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        check(rdata & mask, exp);
    endtask : reg_check

    // Counter read, with or without a coinciding carry
    task automatic pulse_read(input logic with_carry);
        @(posedge core_clk);
        counter_read <= 1'b1;
        sec_carry <= with_carry;
        @(posedge core_clk);
        counter_read <= 1'b0;
        sec_carry <= 1'b0;
        #1;
    endtask : pulse_read

    // Wait for the periodic request, bounded
    task automatic wait_irq(input int limit);
        int n;
        n = 0;
        while (periodic_irq !== 1'b1 && n < limit) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_irq

    // Power-on values and an unmapped address
    task automatic t_reset();
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h00);
        reg_check(rtcac_pkg::RUN_CTRL_OFS, 8'hFF, 8'h09);
        reg_check(rtcac_pkg::MON_ALARM_OFS, 8'h80, 8'h00);
        check({4'h0, osc_run, count_run, carry_irq, alarm_irq}, 8'h0C);
        reg_write(8'h10, 8'hFF);
        reg_check(8'h10, 8'hFF, 8'h00);
    endtask : t_reset

    // Alarm coincidence, masking by other fields and flag writes
    task automatic t_alarm();
        reg_write(rtcac_pkg::MON_ALARM_OFS, 8'hF2);
        reg_check(rtcac_pkg::MON_ALARM_OFS, 8'hFF, 8'h92);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h08);
        other_alarm_any_en <= 1'b1;
        other_alarm_match <= 1'b0;
        month_counter <= 8'h12;
        repeat (4) @(posedge core_clk);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h08);
        other_alarm_match <= 1'b1;
        repeat (3) @(posedge core_clk);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h09);
        check_bit(alarm_irq, 1'b1);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h09);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h09);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h00);
        check_bit(alarm_irq, 1'b0);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h00);
        month_counter <= 8'h11;
        repeat (3) @(posedge core_clk);
        month_counter <= 8'h12;
        repeat (3) @(posedge core_clk);
        check_bit(alarm_irq, 1'b0);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h01);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h00);
        month_counter <= 8'h11;
        other_alarm_any_en <= 1'b0;
        other_alarm_match <= 1'b1;
    endtask : t_alarm

    // Carry flag writes, reserved bits and carry during a counter read
    task automatic t_carry();
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h80);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h80);
        check_bit(carry_irq, 1'b0);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h10);
        check_bit(carry_irq, 1'b0);
        pulse_read(1'b0);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h10);
        pulse_read(1'b1);
        check_bit(carry_irq, 1'b1);
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'hFF, 8'h90);
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h00);
        check_bit(carry_irq, 1'b0);
    endtask : t_carry

    // Round pulse, write-only bits and every select code
    task automatic t_round();
        reg_write(rtcac_pkg::RUN_CTRL_OFS, 8'h0D);
        check_bit(thirty_second_round, 1'b1);
        @(posedge core_clk);
        #1;
        check_bit(thirty_second_round, 1'b0);
        reg_write(rtcac_pkg::RUN_CTRL_OFS, 8'h0B);
        reg_check(rtcac_pkg::RUN_CTRL_OFS, 8'hFF, 8'h09);
        for (int c = 0; c < 8; c++) begin
            reg_write(rtcac_pkg::RUN_CTRL_OFS, {1'b0, c[2:0], 4'h9});
            reg_check(rtcac_pkg::RUN_CTRL_OFS, 8'h7F, {1'b0, c[2:0], 4'h9});
        end
    endtask : t_round

    // Periodic spacing after a divider reset, counters stopped
    task automatic t_period(input int c);
        int p;
        int t0;
        p = 1024 << (2 * (c - 1));
        reg_write(rtcac_pkg::RUN_CTRL_OFS, {1'b0, c[2:0], 4'hA});
        t0 = cyc;
        wait_irq(p + 64);
        check_near(cyc - t0, p);
        t0 = cyc;
        reg_write(rtcac_pkg::RUN_CTRL_OFS, {1'b0, c[2:0], 4'h8});
        check_bit(periodic_irq, 1'b0);
        wait_irq(p + 64);
        check_near(cyc - t0, p);
    endtask : t_period

    // No periodic request with select none or oscillator halted
    task automatic t_quiet();
        reg_write(rtcac_pkg::RUN_CTRL_OFS, 8'h0A);
        repeat (1500) @(posedge core_clk);
        check_bit(periodic_irq, 1'b0);
        reg_write(rtcac_pkg::RUN_CTRL_OFS, 8'h12);
        check({6'h00, osc_run, count_run}, 8'h00);
        repeat (1500) @(posedge core_clk);
        check_bit(periodic_irq, 1'b0);
        check_bit(sec_tick, 1'b0);
    endtask : t_quiet

    // Manual reset keeps run bits and month alarm
    task automatic t_manual();
        reg_write(rtcac_pkg::FLAG_CTRL_OFS, 8'h98);
        reg_write(rtcac_pkg::RUN_CTRL_OFS, 8'h31);
        @(posedge core_clk);
        manual_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        manual_rst <= 1'b0;
        reg_check(rtcac_pkg::FLAG_CTRL_OFS, 8'h7F, 8'h00);
        check_bit(carry_irq, 1'b0);
        reg_check(rtcac_pkg::RUN_CTRL_OFS, 8'hFF, 8'h01);
        reg_check(rtcac_pkg::MON_ALARM_OFS, 8'hFF, 8'h92);
    endtask : t_manual

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("mismatches %0d, compares %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {manual_rst, wr, rd, counter_read, sec_carry, other_alarm_any_en} = 6'h00;
        {addr, wdata} = 16'h0000;
        month_counter = 8'h11;
        other_alarm_match = 1'b1;
        rtc_crystal_pin = 1'b0;
        {mismatches, check_count, cyc, xdiv} = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_alarm();
        t_carry();
        t_round();
        for (int c = 1; c < 4; c++) begin
            t_period(c);
        end
        t_quiet();
        t_manual();
        conclude();
    end
endmodule : testbench
